// ==== logic/upc_pkg.sv ====
package upc_pkg;
    localparam int DATA_W = 8;
    localparam int IE_BYTES = 4;
    localparam int EP_COUNT = 16;
    localparam int BUF_DEPTH = 66;
    localparam int PTR_W = 7;
    localparam int LEN_BYTES = 2;
    localparam logic [31:0] IE_RESET = 32'h0000_0000;
    localparam logic [31:0] IE_WRITABLE = 32'h00ff_ff7f;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] CMD_IE_WRITE = 8'hc2;
    localparam logic [7:0] CMD_IE_READ = 8'hc3;
    localparam logic [7:0] CMD_RESET = 8'hf6;
    localparam logic [7:0] CMD_BUFWR_LO = 8'h01;
    localparam logic [7:0] CMD_BUFWR_HI = 8'h0f;
    localparam logic [7:0] CMD_BUFRD_LO = 8'h10;
    localparam logic [7:0] CMD_BUFRD_HI = 8'h1f;
    localparam logic [7:0] CMD_BUFRD_BAD = 8'h11;
    localparam logic [7:0] CMD_STAT_LO = 8'h50;
    localparam logic [7:0] CMD_STAT_HI = 8'h5f;
    localparam int IE_EP1_BIT = 10;
    localparam int IE_CTRL_IN_BIT = 9;
    localparam int IE_CTRL_OUT_BIT = 8;
    localparam int IE_SHORT_BIT = 6;
    localparam int IE_PSOF_BIT = 5;
    localparam int IE_SOF_BIT = 4;
    localparam int IE_EOT_BIT = 3;
    localparam int IE_SUSP_BIT = 2;
    localparam int IE_RESM_BIT = 1;
    localparam int IE_BRST_BIT = 0;
    localparam int EVT_COUNT = 7;
    typedef enum logic [2:0] {
        UPC_IDLE = 3'b000,
        UPC_IEW = 3'b001,
        UPC_IER = 3'b011,
        UPC_BUFW = 3'b010,
        UPC_BUFR = 3'b110,
        UPC_STAT = 3'b111
    } upc_phase_t;
    typedef enum logic [1:0] {
        UPH_IDLE = 2'b00,
        UPH_CMD = 2'b01,
        UPH_DATA = 2'b11,
        UPH_WAIT = 2'b10
    } upc_hstate_t;
endpackage

// ==== logic/upc_bus_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface upc_bus_if;
    logic cmd_data_select;
    logic wr_n;
    logic rd_n;
    logic dma_mode;
    logic end_of_packet;
    logic [7:0] host_dq;
    logic host_dq_oe;
    logic [7:0] dev_dq;
    logic dev_dq_oe;
    wire logic [7:0] dq_level = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : 8'h00);
    modport dev (input cmd_data_select, input wr_n, input rd_n, input dma_mode,
        input end_of_packet, input dq_level, output dev_dq, output dev_dq_oe);
    modport host (output cmd_data_select, output wr_n, output rd_n, output dma_mode,
        output end_of_packet, input dq_level, output host_dq, output host_dq_oe);
endinterface
`default_nettype wire

// ==== logic/upc_device.sv ====
//
// Contract
// [R1] interrupt enable moves as four data bytes
// [R2] host writes zero into top byte
// [R3] bits 23..10 gate endpoints 14..1
// [R4] bit 9 ctrl in, bit 8 ctrl out
// [R5] bit 5 gates 1 ms pseudo frame
// [R6] bits 4,3,6: frame, transfer end, short
// [R7] bits 2,1,0: suspend, resume, bus reset
// [R8] reset command equals hardware reset
// [R9] select high command, low data bytes
// [R10] buffer command rewinds buffer pointer
// [R11] pointer advances per byte, N+2 max
// [R12] 01h-0Fh write, 10h,12h-1Fh read buffers
// [R13] buffer size limit 1023 or 64
// [R14] length low, length high, then payload
// [R15] dma skips the two length bytes
// [R16] dma read ends on end of packet
// [R17] host fills bulk IN buffer completely
// [R18] no reads after write command, vice versa
// [R19] no overrun or wrong-direction access
// [R20] dma double buffer rolls to secondary
// [R21] 50h-5Fh read status, clear ep irq
// [R22] status byte read-only, reset zero
// [R23] C2h writes, C3h reads, bus reset keeps
// [R24] enable bytes least significant first
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module upc_device (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    upc_bus_if.dev bus,
    input wire logic [upc_pkg::EP_COUNT-1:0] ep_event,
    input wire logic [upc_pkg::EVT_COUNT-1:0] bus_event,
    input wire logic [upc_pkg::EP_COUNT-1:0] stall_set,
    input wire logic [upc_pkg::EP_COUNT-1:0] stall_clr,
    input wire logic [upc_pkg::EP_COUNT-1:0] setup_rx,
    input wire logic [upc_pkg::EP_COUNT-1:0] double_buf,
    input wire logic [upc_pkg::EP_COUNT*6-1:0] ep_flags,
    output logic [31:0] irq_enable,
    output logic [upc_pkg::EP_COUNT-1:0] ep_irq_pending,
    output logic irq,
    output logic dma_last_byte
);
    localparam int NB = upc_pkg::EP_COUNT * 2 * upc_pkg::BUF_DEPTH;
    upc_pkg::upc_phase_t phase_r;
    logic [31:0] ie_r;
    logic [1:0] byte_r;
    logic [3:0] ep_r;
    logic half_r;
    logic [upc_pkg::PTR_W-1:0] ptr_r;
    logic [7:0] mem_r [NB];
    logic [upc_pkg::EP_COUNT-1:0] pend_r;
    logic [upc_pkg::EP_COUNT-1:0] halt_r;
    logic [upc_pkg::EP_COUNT-1:0] sel_r;
    logic [7:0] rdata_r;
    logic soft_rst_r;
    logic wr_edge, rd_edge, cmd_wr, data_wr, wr_n_d, rd_n_d;
    logic [7:0] cmd;
    logic [7:0] status;
    logic [31:0] ep_gate;
    logic [11:0] addr;
    logic [upc_pkg::PTR_W-1:0] ptr_skip;
    logic at_end;

    // strobes are acted on at their rising edge, once per bus cycle; read data is latched as rd_n falls
    assign wr_edge = bus.wr_n & ~wr_n_d;
    assign rd_edge = bus.rd_n & ~rd_n_d;
    assign cmd = bus.dq_level;
    assign cmd_wr = wr_edge & bus.cmd_data_select; // R9
    assign data_wr = wr_edge & ~bus.cmd_data_select; // R9
    assign ptr_skip = (bus.dma_mode && ptr_r < upc_pkg::PTR_W'(upc_pkg::LEN_BYTES))
        ? upc_pkg::PTR_W'(upc_pkg::LEN_BYTES) : ptr_r; // R15 R14
    assign at_end = ptr_skip == upc_pkg::PTR_W'(upc_pkg::BUF_DEPTH - 1);
    assign addr = 12'((ep_r * 2 + half_r) * upc_pkg::BUF_DEPTH + ptr_skip);
    assign status = {halt_r[ep_r], ep_flags[ep_r*6 +: 5], sel_r[ep_r], 1'b0}; // R22

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_n_d <= 1'b1;
            rd_n_d <= 1'b1;
        end else if (clk_en) begin
            wr_n_d <= bus.wr_n;
            rd_n_d <= bus.rd_n;
        end
    end

    // reset command held one cycle, then all registers except the buffer memory, strobe history and dma_last_byte return to reset values
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            soft_rst_r <= 1'b0;
        end else if (clk_en) begin
            soft_rst_r <= cmd_wr && cmd == upc_pkg::CMD_RESET; // R8
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_r <= upc_pkg::UPC_IDLE;
            ep_r <= 4'h0;
        end else if (clk_en) begin
            if (soft_rst_r) begin
                phase_r <= upc_pkg::UPC_IDLE; // R8
                ep_r <= 4'h0;
            end else if (cmd_wr) begin
                ep_r <= cmd[3:0];
                case (cmd) inside
                    upc_pkg::CMD_IE_WRITE: phase_r <= upc_pkg::UPC_IEW; // R23
                    upc_pkg::CMD_IE_READ: phase_r <= upc_pkg::UPC_IER; // R23
                    [upc_pkg::CMD_BUFWR_LO:upc_pkg::CMD_BUFWR_HI]: phase_r <= upc_pkg::UPC_BUFW; // R12
                    upc_pkg::CMD_BUFRD_BAD: phase_r <= upc_pkg::UPC_IDLE;
                    [upc_pkg::CMD_BUFRD_LO:upc_pkg::CMD_BUFRD_HI]: phase_r <= upc_pkg::UPC_BUFR; // R12
                    [upc_pkg::CMD_STAT_LO:upc_pkg::CMD_STAT_HI]: phase_r <= upc_pkg::UPC_STAT; // R21
                    default: phase_r <= upc_pkg::UPC_IDLE;
                endcase
            end else if ((phase_r == upc_pkg::UPC_STAT && rd_edge)
                    || ((phase_r == upc_pkg::UPC_IEW || phase_r == upc_pkg::UPC_IER)
                    && (wr_edge || rd_edge) && byte_r == 2'(upc_pkg::IE_BYTES - 1))) begin
                phase_r <= upc_pkg::UPC_IDLE; // R1
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            byte_r <= 2'h0;
        end else if (clk_en) begin
            if (soft_rst_r || cmd_wr) begin
                byte_r <= 2'h0;
            end else if ((phase_r == upc_pkg::UPC_IEW && data_wr)
                    || (phase_r == upc_pkg::UPC_IER && rd_edge)) begin
                byte_r <= byte_r + 2'h1; // R24
            end
        end
    end

    // a usb bus reset leaves this register alone; only resets and C2h writes touch it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ie_r <= upc_pkg::IE_RESET;
        end else if (clk_en) begin
            if (soft_rst_r) begin
                ie_r <= upc_pkg::IE_RESET; // R8 R23
            end else if (phase_r == upc_pkg::UPC_IEW && data_wr) begin
                ie_r[byte_r*8 +: 8] <= cmd & upc_pkg::IE_WRITABLE[byte_r*8 +: 8]; // R1 R24 R2
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ptr_r <= '0;
            half_r <= 1'b0;
        end else if (clk_en) begin
            if (soft_rst_r || cmd_wr) begin
                ptr_r <= '0; // R10
                half_r <= 1'b0;
            end else if ((phase_r == upc_pkg::UPC_BUFW && data_wr)
                    || (phase_r == upc_pkg::UPC_BUFR && rd_edge)) begin
                if (at_end && bus.dma_mode && double_buf[ep_r] && !half_r) begin
                    half_r <= 1'b1; // R20
                    ptr_r <= '0;
                end else if (!at_end) begin
                    ptr_r <= ptr_skip + 1'b1; // R11
                end
            end
        end
    end

    // no overrun protection beyond clamping at the buffer end
    always_ff @(posedge clk) begin
        if (clk_en && phase_r == upc_pkg::UPC_BUFW && data_wr) begin
            mem_r[addr] <= cmd; // R11 R14
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 8'h00;
        end else if (clk_en && soft_rst_r) begin
            rdata_r <= 8'h00; // R8
        end else if (clk_en && !bus.rd_n && rd_n_d) begin
            case (phase_r)
                upc_pkg::UPC_IER: rdata_r <= ie_r[byte_r*8 +: 8]; // R24
                upc_pkg::UPC_BUFR: rdata_r <= mem_r[addr]; // R11
                upc_pkg::UPC_STAT: rdata_r <= status; // R21
                default: rdata_r <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dma_last_byte <= 1'b0;
        end else if (clk_en) begin
            dma_last_byte <= phase_r == upc_pkg::UPC_BUFR && bus.dma_mode
                && rd_edge && bus.end_of_packet; // R16
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            halt_r <= '0;
            sel_r <= '0;
        end else if (clk_en) begin
            if (soft_rst_r) begin
                halt_r <= '0; // R22
                sel_r <= '0;
            end else begin
                halt_r <= (halt_r | stall_set) & ~stall_clr & ~setup_rx; // R22
                sel_r <= double_buf & (sel_r ^ (ep_event & double_buf));
            end
        end
    end

    // new event wins over a status-read clear in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pend_r <= '0;
        end else if (clk_en) begin
            if (soft_rst_r) begin
                pend_r <= '0;
            end else if (phase_r == upc_pkg::UPC_STAT && rd_edge) begin
                pend_r <= (pend_r & ~(16'h0001 << ep_r)) | ep_event; // R21
            end else begin
                pend_r <= pend_r | ep_event;
            end
        end
    end

    // pending ep i pairs with enable bit 8+i: ctrl out, ctrl in, ep1..ep14
    assign ep_gate = ie_r >> upc_pkg::IE_CTRL_OUT_BIT; // R3 R4
    assign irq = |(pend_r & ep_gate[upc_pkg::EP_COUNT-1:0]) // R3 R4
        | |(bus_event & ie_r[upc_pkg::EVT_COUNT-1:0]); // R5 R6 R7
    assign irq_enable = ie_r;
    assign ep_irq_pending = pend_r;
    assign bus.dev_dq = rdata_r;
    // byte is latched as the strobe falls, so it must stand one cycle past its rise
    assign bus.dev_dq_oe = (!bus.rd_n || rd_edge) && phase_r != upc_pkg::UPC_IDLE; // R9
endmodule
`default_nettype wire

// ==== logic/upc_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module upc_host (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    upc_bus_if.host bus,
    input wire logic req_valid,
    input wire logic req_is_cmd,
    input wire logic req_is_read,
    input wire logic [7:0] req_data,
    input wire logic req_dma,
    input wire logic req_eop,
    output logic req_ready,
    output logic [7:0] rsp_data,
    output logic rsp_valid
);
    upc_pkg::upc_hstate_t st_r;
    logic rd_r;
    logic [7:0] last_cmd_r;

    // one bus cycle: strobe low one clock, high three clocks
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= upc_pkg::UPH_IDLE;
            rd_r <= 1'b0;
            bus.cmd_data_select <= 1'b0;
            bus.wr_n <= 1'b1;
            bus.rd_n <= 1'b1;
            bus.dma_mode <= 1'b0;
            bus.end_of_packet <= 1'b0;
            bus.host_dq <= 8'h00;
            bus.host_dq_oe <= 1'b0;
            last_cmd_r <= 8'h00;
        end else if (clk_en) begin
            case (st_r)
                upc_pkg::UPH_IDLE: begin
                    if (req_valid) begin
                        st_r <= upc_pkg::UPH_CMD;
                        rd_r <= req_is_read && !req_is_cmd;
                        bus.cmd_data_select <= req_is_cmd; // R9
                        bus.host_dq <= req_data;
                        bus.host_dq_oe <= !(req_is_read && !req_is_cmd);
                        bus.dma_mode <= req_dma;
                        bus.end_of_packet <= req_eop;
                        if (req_is_cmd) begin
                            last_cmd_r <= req_data;
                        end
                    end
                end
                upc_pkg::UPH_CMD: begin
                    st_r <= upc_pkg::UPH_DATA;
                    bus.wr_n <= rd_r;
                    bus.rd_n <= !rd_r;
                end
                upc_pkg::UPH_DATA: begin
                    st_r <= upc_pkg::UPH_WAIT;
                    bus.wr_n <= 1'b1;
                    bus.rd_n <= 1'b1;
                end
                upc_pkg::UPH_WAIT: begin
                    st_r <= upc_pkg::UPH_IDLE;
                    bus.host_dq_oe <= 1'b0;
                    bus.end_of_packet <= 1'b0;
                end
                default: st_r <= upc_pkg::UPH_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rsp_data <= 8'h00;
            rsp_valid <= 1'b0;
        end else if (clk_en) begin
            rsp_valid <= st_r == upc_pkg::UPH_WAIT && rd_r;
            if (st_r == upc_pkg::UPH_WAIT && rd_r) begin
                rsp_data <= bus.dq_level;
            end
        end
    end

    // direction is software's job; host does not police it
    assign req_ready = st_r == upc_pkg::UPH_IDLE; // R18 R19 R17 R13
endmodule
`default_nettype wire

// ==== tb/upc_bus_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module upc_bus_properties (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cmd_data_select,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic dma_mode,
    input wire logic end_of_packet,
    input wire logic [7:0] host_dq,
    input wire logic host_dq_oe,
    input wire logic dev_dq_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_one_driver: assert property (!(host_dq_oe && dev_dq_oe))
        else $error("both ends drive the data lines");
    a_strobe_excl: assert property (!(!wr_n && !rd_n))
        else $error("read and write strobes low together");
    a_write_driven: assert property (!wr_n |-> host_dq_oe)
        else $error("write strobe without host data");
    a_read_data: assert property (!rd_n |-> !cmd_data_select)
        else $error("read strobe in command phase");
    a_write_pulse: assert property (!wr_n |=> wr_n)
        else $error("write strobe longer than one cycle");
    a_read_pulse: assert property (!rd_n |=> rd_n)
        else $error("read strobe longer than one cycle");
    // select and byte must settle a cycle before the strobe
    a_write_setup: assert property (!wr_n |-> $stable(host_dq) && $stable(cmd_data_select))
        else $error("write byte moved under the strobe");
    a_read_answer: assert property ($fell(rd_n) |-> ##[0:1] dev_dq_oe)
        else $error("device did not answer a read");
    a_eop_dma: assert property (end_of_packet |-> dma_mode)
        else $error("end of packet outside dma access");
endmodule
`default_nettype wire

// ==== tb/test_usb_periph_cmd_ep_access.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module test_usb_periph_cmd_ep_access;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic req_valid = 1'b0;
    logic req_is_cmd = 1'b0;
    logic req_is_read = 1'b0;
    logic req_dma = 1'b0;
    logic req_eop = 1'b0;
    logic [7:0] req_data = 8'h00;
    logic [15:0] ep_event = 16'h0000;
    logic [15:0] stall_set = 16'h0000;
    logic [15:0] stall_clr = 16'h0000;
    logic [15:0] setup_rx = 16'h0000;
    logic [15:0] double_buf = 16'h0000;
    logic [6:0] bus_event = 7'h00;
    logic [95:0] ep_flags = 96'h0;
    logic req_ready, rsp_valid, irq, dma_last_byte;
    logic [7:0] rsp_data, q;
    logic [31:0] irq_enable;
    logic [15:0] ep_irq_pending;
    logic [7:0] pk [5] = '{8'h03, 8'h00, 8'ha1, 8'ha2, 8'ha3};
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int eop_seen = 0;
    always #50 clk = ~clk;
    upc_bus_if upc_bus_if_inst ();
    upc_device upc_device_inst (.clk(clk), .rstn(rstn), .clk_en(1'b1), .bus(upc_bus_if_inst.dev),
        .ep_event(ep_event), .bus_event(bus_event), .stall_set(stall_set), .stall_clr(stall_clr),
        .setup_rx(setup_rx), .double_buf(double_buf), .ep_flags(ep_flags),
        .irq_enable(irq_enable), .ep_irq_pending(ep_irq_pending), .irq(irq),
        .dma_last_byte(dma_last_byte));
    upc_host upc_host_inst (.clk(clk), .rstn(rstn), .clk_en(1'b1), .bus(upc_bus_if_inst.host),
        .req_valid(req_valid), .req_is_cmd(req_is_cmd), .req_is_read(req_is_read),
        .req_data(req_data), .req_dma(req_dma), .req_eop(req_eop), .req_ready(req_ready),
        .rsp_data(rsp_data), .rsp_valid(rsp_valid));
    upc_bus_properties upc_bus_properties_inst (.clk(clk), .rstn(rstn),
        .cmd_data_select(upc_bus_if_inst.cmd_data_select), .wr_n(upc_bus_if_inst.wr_n),
        .rd_n(upc_bus_if_inst.rd_n), .dma_mode(upc_bus_if_inst.dma_mode),
        .end_of_packet(upc_bus_if_inst.end_of_packet), .host_dq(upc_bus_if_inst.host_dq),
        .host_dq_oe(upc_bus_if_inst.host_dq_oe), .dev_dq_oe(upc_bus_if_inst.dev_dq_oe));
    task automatic stop_test();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // starts one edge late so two calls never assign at the same step
    task automatic xfer(input logic c, input logic r, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_is_cmd <= c;
        req_is_read <= r;
        req_data <= d;
        @(posedge clk);
        while (req_ready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        req_valid <= 1'b0;
        @(posedge clk);
        while (r && rsp_valid !== 1'b1 && n < 40) begin
            n++;
            @(posedge clk);
        end
        q = rsp_data;
    endtask
    task automatic cmd(input logic [7:0] c);
        xfer(1'b1, 1'b0, c);
    endtask
    task automatic wrb(input logic [7:0] d);
        xfer(1'b0, 1'b0, d);
    endtask
    task automatic rd(input logic [7:0] e);
        xfer(1'b0, 1'b1, 8'h00);
        `CHK("rsp_data", e, q)
    endtask
    task automatic ie_w(input logic [31:0] v);
        cmd(upc_pkg::CMD_IE_WRITE);
        for (int k = 0; k < 4; k++) wrb(v[8*k+:8]);
        // device acts three cycles after the host takes the last byte
        repeat (4) @(posedge clk);
    endtask
    task automatic ie_r(input logic [31:0] v);
        cmd(upc_pkg::CMD_IE_READ);
        for (int k = 0; k < 4; k++) rd(v[8*k+:8]);
    endtask
    task automatic kick(input int k, input int i);
        @(posedge clk);
        case (k)
            0: ep_event[i] <= 1'b1;
            1: stall_set[i] <= 1'b1;
            2: stall_clr[i] <= 1'b1;
            default: setup_rx[i] <= 1'b1;
        endcase
        @(posedge clk);
        ep_event <= 16'h0000;
        stall_set <= 16'h0000;
        stall_clr <= 16'h0000;
        setup_rx <= 16'h0000;
        @(posedge clk);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (dma_last_byte === 1'b1) begin
            eop_seen++;
        end
        if (cycles == 20000) begin
            err_count++;
            stop_test();
        end
    end
    initial begin
        int j;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        ie_r(32'h0000_0000);
        ie_w(32'h00a5_c37f);
        ie_r(32'h00a5_c37f);
        @(negedge clk);
        `CHK("irq_enable", 32'h00a5_c37f, irq_enable)
        for (int i = 0; i < 16; i++) begin
            j = (i + 1) % 16;
            ie_w(32'h1 << (8 + i));
            kick(0, j);
            @(negedge clk);
            `CHK("irq", 1'b0, irq)
            kick(0, i);
            @(negedge clk);
            `CHK("irq", 1'b1, irq)
            cmd(upc_pkg::CMD_STAT_LO + 8'(i));
            rd(8'h00);
            cmd(upc_pkg::CMD_STAT_LO + 8'(j));
            rd(8'h00);
            @(negedge clk);
            `CHK("pending", 16'h0000, ep_irq_pending)
        end
        for (int b = 0; b < 7; b++) begin
            ie_w(32'h1 << b);
            bus_event <= 7'h7f ^ (7'h01 << b);
            repeat (2) @(posedge clk);
            `CHK("irq", 1'b0, irq)
            bus_event <= 7'h01 << b;
            repeat (2) @(posedge clk);
            `CHK("irq", 1'b1, irq)
        end
        bus_event <= 7'h00;
        ep_flags[17:12] <= 6'h1f;
        cmd(8'h52);
        rd(8'h7c);
        kick(1, 2);
        cmd(8'h52);
        rd(8'hfc);
        kick(2, 2);
        cmd(8'h52);
        rd(8'h7c);
        kick(1, 2);
        kick(3, 2);
        cmd(8'h52);
        rd(8'h7c);
        for (int i = 1; i < 16; i++) begin
            cmd(8'(i));
            wrb(8'(i));
            wrb(8'h00);
        end
        cmd(8'h10);
        xfer(1'b0, 1'b1, 8'h00);
        for (int i = 2; i < 16; i++) begin
            cmd(8'h10 + 8'(i));
            rd(8'(i));
        end
        cmd(8'h02);
        foreach (pk[k]) wrb(pk[k]);
        cmd(8'h12);
        foreach (pk[k]) rd(pk[k]);
        cmd(8'h12);
        rd(8'h03);
        req_dma <= 1'b1;
        cmd(8'h12);
        rd(8'ha1);
        rd(8'ha2);
        req_eop <= 1'b1;
        rd(8'ha3);
        @(posedge clk);
        req_dma <= 1'b0;
        req_eop <= 1'b0;
        ep_flags <= 96'h0;
        @(negedge clk);
        `CHK("dma_last_byte", 1, eop_seen)
        kick(1, 2);
        // dma on a double-buffered endpoint rolls into the secondary half
        double_buf <= 16'h0008;
        req_dma <= 1'b1;
        cmd(8'h03);
        for (int k = 0; k < 65; k++) wrb(8'(k));
        cmd(8'h13);
        for (int k = 0; k < 65; k++) rd(8'(k));
        req_dma <= 1'b0;
        kick(0, 3);
        cmd(8'h53);
        rd(8'h02);
        double_buf <= 16'h0000;
        ie_w(32'h0012_3456);
        cmd(upc_pkg::CMD_BUFRD_BAD);
        ie_r(32'h0012_3456);
        cmd(upc_pkg::CMD_RESET);
        repeat (6) @(posedge clk);
        @(negedge clk);
        `CHK("irq_enable", 32'h0000_0000, irq_enable)
        ie_r(32'h0000_0000);
        cmd(8'h52);
        rd(8'h00);
        stop_test();
    end
endmodule
`default_nettype wire
